// ===== core/estx_exec.sv
// estx_exec: executes zero-test skips, table reads and xor operations for one instruction
// assumes: decoder presents one request per instruction with the addressed byte already read;
// program memory answers a table fetch one cycle after the address is shown
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module estx_exec #(
   parameter int unsigned PM_ADDR_W = 16,
   parameter int unsigned PM_DATA_W = 16
) (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire estx_pkg::estx_req_s     req,
   input  wire logic [PM_DATA_W-1:0]    pmData,
   output logic [PM_ADDR_W-1:0]         pmAddr,
   output logic                         pmRead,
   output logic [7:0]                   tablePointerLow,
   output logic [7:0]                   tablePointerHigh,
   output logic [7:0]                   tableHighByteReg,
   output estx_pkg::estx_out_s          result
);
   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (PM_ADDR_W < 9 || PM_ADDR_W > 16) begin : g_addr_w_check
      $error("PM_ADDR_W must lie between 9 and 16");
   end
   if (PM_DATA_W < 9 || PM_DATA_W > 16) begin : g_data_w_check
      $error("PM_DATA_W must lie between 9 and 16");
   end

   localparam int unsigned HI_W = PM_ADDR_W - estx_pkg::PTR_W;
   localparam int unsigned HB_W = PM_DATA_W - estx_pkg::DATA_W;

   typedef struct packed {
      estx_pkg::estx_state_e state;
      logic [PM_ADDR_W-1:0]  pmAddr;
      logic                  pmRead;
      logic [7:0]            ptrLow;
      logic [7:0]            ptrHigh;
      logic [7:0]            tblHigh;
      logic [1:0]            skipCnt;
      estx_pkg::estx_out_s   out;
   } estx_st_s;

   estx_st_s st_reg;
   estx_st_s st_next;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   logic [7:0] xorVal;
   logic [7:0] incLow;
   logic       byteZero;
   logic       bitZero;
   logic [7:0] lowSel;

   assign xorVal   = st_reg.out.acc ^ req.memData;
   assign incLow   = st_reg.ptrLow + 8'h01;
   assign byteZero = (req.memData == estx_pkg::BYTE_ZERO);
   assign bitZero  = ~req.memData[req.bitSel];
   assign lowSel   = (req.op == estx_pkg::ESTX_OP_TABLE_PAGED_INC || req.op == estx_pkg::ESTX_OP_TABLE_LAST_INC)
                   ? incLow : st_reg.ptrLow;

   always_comb begin
      st_next               = st_reg;
      st_next.pmRead        = 1'b0;
      st_next.out.memWe     = 1'b0;
      st_next.out.accWe     = 1'b0;
      st_next.out.zeroWe    = 1'b0;
      st_next.out.done      = 1'b0;
      st_next.out.skipReq   = 1'b0;
      case (st_reg.state)
         estx_pkg::ESTX_ST_IDLE: begin
            st_next.out.busy = 1'b0;
            if (req.valid) begin
               case (req.op)
                  estx_pkg::ESTX_OP_SKIP_BYTE_ZERO: begin
                     // write-back keeps the read-modify-write timing of the memory port
                     st_next.out.memWe    = 1'b1;
                     st_next.out.memWdata = req.memData;
                     st_next.out.done     = 1'b1;
                     if (byteZero) begin
                        st_next.out.skipReq = 1'b1;
                        st_next.out.busy    = 1'b1;
                        st_next.skipCnt     = estx_pkg::SKIP_CYCLES;
                        st_next.state       = estx_pkg::ESTX_ST_DUMMY;
                     end
                  end
                  estx_pkg::ESTX_OP_SKIP_ZERO_COPY: begin
                     st_next.out.accWe = 1'b1;
                     st_next.out.acc   = req.memData;
                     st_next.out.done  = 1'b1;
                     if (byteZero) begin
                        st_next.out.skipReq = 1'b1;
                        st_next.out.busy    = 1'b1;
                        st_next.skipCnt     = estx_pkg::SKIP_CYCLES;
                        st_next.state       = estx_pkg::ESTX_ST_DUMMY;
                     end
                  end
                  estx_pkg::ESTX_OP_SKIP_BIT_ZERO: begin
                     st_next.out.done = 1'b1;
                     if (bitZero) begin
                        st_next.out.skipReq = 1'b1;
                        st_next.out.busy    = 1'b1;
                        st_next.skipCnt     = estx_pkg::SKIP_CYCLES;
                        st_next.state       = estx_pkg::ESTX_ST_DUMMY;
                     end
                  end
                  estx_pkg::ESTX_OP_TABLE_PAGED,
                  estx_pkg::ESTX_OP_TABLE_PAGED_INC: begin
                     st_next.ptrLow   = lowSel;
                     st_next.pmAddr   = {st_reg.ptrHigh[HI_W-1:0], lowSel};
                     st_next.pmRead   = 1'b1;
                     st_next.out.busy = 1'b1;
                     st_next.state    = estx_pkg::ESTX_ST_FETCH;
                  end
                  estx_pkg::ESTX_OP_TABLE_LAST,
                  estx_pkg::ESTX_OP_TABLE_LAST_INC: begin
                     st_next.ptrLow   = lowSel;
                     // last page: all upper address bits set, high pointer ignored
                     st_next.pmAddr   = {{HI_W{1'b1}}, lowSel};
                     st_next.pmRead   = 1'b1;
                     st_next.out.busy = 1'b1;
                     st_next.state    = estx_pkg::ESTX_ST_FETCH;
                  end
                  estx_pkg::ESTX_OP_XOR_ACC: begin
                     st_next.out.accWe    = 1'b1;
                     st_next.out.acc      = xorVal;
                     st_next.out.zeroWe   = 1'b1;
                     st_next.out.zeroFlag = (xorVal == estx_pkg::BYTE_ZERO);
                     st_next.out.done     = 1'b1;
                  end
                  estx_pkg::ESTX_OP_XOR_MEM: begin
                     st_next.out.memWe    = 1'b1;
                     st_next.out.memWdata = xorVal;
                     st_next.out.zeroWe   = 1'b1;
                     st_next.out.zeroFlag = (xorVal == estx_pkg::BYTE_ZERO);
                     st_next.out.done     = 1'b1;
                  end
                  default: begin
                     st_next.out.busy = 1'b0;
                  end
               endcase
            end
         end
         estx_pkg::ESTX_ST_FETCH: begin
            st_next.state = estx_pkg::ESTX_ST_DONE;
         end
         estx_pkg::ESTX_ST_DONE: begin
            st_next.out.memWe    = 1'b1;
            st_next.out.memWdata = pmData[7:0];
            st_next.tblHigh      = 8'h00;
            st_next.tblHigh[HB_W-1:0] = pmData[PM_DATA_W-1:estx_pkg::DATA_W];
            st_next.out.done     = 1'b1;
            st_next.out.busy     = 1'b0;
            st_next.state        = estx_pkg::ESTX_ST_IDLE;
         end
         estx_pkg::ESTX_ST_DUMMY: begin
            // dummy slot: fetched instruction is discarded by the pipeline
            st_next.skipCnt = st_reg.skipCnt - 2'h1;
            if (st_reg.skipCnt == 2'h1) begin
               st_next.out.busy = 1'b0;
               st_next.state    = estx_pkg::ESTX_ST_IDLE;
            end
         end
         default: begin
            st_next.state = estx_pkg::ESTX_ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg         <= '0;
         st_reg.state   <= estx_pkg::ESTX_ST_IDLE;
         st_reg.ptrLow  <= estx_pkg::PTR_RST;
         st_reg.ptrHigh <= estx_pkg::PTR_RST;
         st_reg.out.acc <= estx_pkg::ACC_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pmAddr           = st_reg.pmAddr;
   assign pmRead           = st_reg.pmRead;
   assign tablePointerLow  = st_reg.ptrLow;
   assign tablePointerHigh = st_reg.ptrHigh;
   assign tableHighByteReg = st_reg.tblHigh;
   assign result           = st_reg.out;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_byte_skip_taken: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_SKIP_BYTE_ZERO)
      |=> result.memWe && result.memWdata == $past(req.memData) && (result.skipReq == ($past(req.memData) == 8'h00)))
      else $error("byte zero-test wrong write-back or skip");

   a_skip_three_cycles: assert property (@(posedge sys_clk) disable iff (reset)
      result.skipReq |-> result.busy ##1 result.busy ##1 !result.busy)
      else $error("skip did not span three cycles");

   a_copy_acc: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_SKIP_ZERO_COPY)
      |=> result.accWe && result.acc == $past(req.memData) && !result.zeroWe)
      else $error("zero-test copy to accumulator wrong");

   a_bit_skip: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_SKIP_BIT_ZERO)
      |=> result.skipReq == !$past(req.memData[req.bitSel]) && !result.zeroWe)
      else $error("bit zero-test skip wrong");

   a_paged_addr: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_TABLE_PAGED)
      |=> pmRead && pmAddr[7:0] == $past(st_reg.ptrLow) ##2 result.memWe && result.done)
      else $error("paged table read address or store wrong");

   a_last_page: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_TABLE_LAST)
      |=> pmAddr[PM_ADDR_W-1:8] == {HI_W{1'b1}})
      else $error("last-page table read not on final page");

   a_preinc_paged: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_TABLE_PAGED_INC)
      |=> tablePointerLow == $past(st_reg.ptrLow) + 8'h01 && pmAddr[7:0] == tablePointerLow)
      else $error("pre-increment paged read wrong pointer");

   a_preinc_last: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_TABLE_LAST_INC)
      |=> tablePointerLow == $past(st_reg.ptrLow) + 8'h01 && pmAddr[7:0] == tablePointerLow)
      else $error("pre-increment last-page read wrong pointer");

   a_xor_acc: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_XOR_ACC)
      |=> result.accWe && !result.memWe && result.zeroFlag == (result.acc == 8'h00))
      else $error("xor into accumulator wrong");

   a_xor_mem: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_XOR_MEM)
      |=> result.memWe && !result.accWe && result.memWdata == ($past(st_reg.out.acc) ^ $past(req.memData)))
      else $error("xor into memory wrong");

   a_xor_mem_zero: assert property (@(posedge sys_clk) disable iff (reset)
      (result.memWe && result.zeroWe) |-> result.zeroFlag == (result.memWdata == 8'h00))
      else $error("xor into memory zero flag wrong");

   a_xor_acc_value: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_XOR_ACC)
      |=> result.zeroWe && result.acc == ($past(st_reg.out.acc) ^ $past(req.memData)))
      else $error("xor into accumulator wrong result");

   a_xor_mem_acc: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_XOR_MEM)
      |=> result.zeroWe && result.acc == $past(st_reg.out.acc))
      else $error("xor into memory disturbed accumulator");

   a_byte_skip_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_SKIP_BYTE_ZERO)
      |=> !result.zeroWe && !result.accWe)
      else $error("byte zero-test touched flags or accumulator");

   a_bit_skip_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_SKIP_BIT_ZERO)
      |=> !result.memWe && !result.accWe)
      else $error("bit zero-test wrote memory or accumulator");

   a_bit_all_ones: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_SKIP_BIT_ZERO)
      && req.memData == estx_pkg::BYTE_ONES |=> !result.skipReq)
      else $error("bit zero-test skipped on all-ones byte");

   a_dummy_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_DUMMY)
      |=> !result.memWe && !result.accWe && !result.done && !result.skipReq)
      else $error("dummy slot produced an action");

   a_paged_high: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_TABLE_PAGED)
      |=> pmAddr[PM_ADDR_W-1:8] == $past(st_reg.ptrHigh[HI_W-1:0]))
      else $error("paged table read ignored high pointer");

   a_table_store: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_DONE)
      |=> result.memWdata == $past(pmData[7:0])
      && tableHighByteReg[HB_W-1:0] == $past(pmData[PM_DATA_W-1:estx_pkg::DATA_W]))
      else $error("table word stored wrongly");

   a_table_no_flags: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_FETCH || st_reg.state == estx_pkg::ESTX_ST_DONE)
      |=> !result.zeroWe && !result.accWe)
      else $error("table read touched flags or accumulator");

   a_last_ptr_hold: assert property (@(posedge sys_clk) disable iff (reset)
      (st_reg.state == estx_pkg::ESTX_ST_IDLE && req.valid && req.op == estx_pkg::ESTX_OP_TABLE_LAST)
      |=> tablePointerLow == $past(st_reg.ptrLow) && pmAddr[7:0] == tablePointerLow)
      else $error("last-page read moved low pointer");
endmodule : estx_exec

// ===== core/estx_pkg.sv
// estx_pkg: constants and carrier types for the skip / table-read / xor execution unit
// assumes: 8-bit data memory, word-wide program memory, single 20 MHz clock
package estx_pkg;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned PTR_W       = 8;
   localparam int unsigned CLK_NS      = 50;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [7:0]  BYTE_ONES   = 8'hFF;
   localparam logic [7:0]  PTR_RST     = 8'h00;
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [1:0]  SKIP_CYCLES = 2'h2;

   // ----------------------------------------------------------------
   // operation codes presented by the decoder
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ESTX_OP_NONE             = 4'h0,
      ESTX_OP_SKIP_BYTE_ZERO   = 4'h1,
      ESTX_OP_SKIP_ZERO_COPY   = 4'h2,
      ESTX_OP_SKIP_BIT_ZERO    = 4'h3,
      ESTX_OP_TABLE_PAGED      = 4'h4,
      ESTX_OP_TABLE_LAST       = 4'h5,
      ESTX_OP_TABLE_PAGED_INC  = 4'h6,
      ESTX_OP_TABLE_LAST_INC   = 4'h7,
      ESTX_OP_XOR_ACC          = 4'h8,
      ESTX_OP_XOR_MEM          = 4'h9
   } estx_op_e;

   typedef enum logic [3:0] {
      ESTX_ST_IDLE  = 4'h1,
      ESTX_ST_FETCH = 4'h2,
      ESTX_ST_DUMMY = 4'h4,
      ESTX_ST_DONE  = 4'h8
   } estx_state_e;

   typedef struct packed {
      logic       valid;
      estx_op_e   op;
      logic [2:0] bitSel;
      logic [7:0] memData;
   } estx_req_s;

   typedef struct packed {
      logic       memWe;
      logic [7:0] memWdata;
      logic       accWe;
      logic [7:0] acc;
      logic       zeroWe;
      logic       zeroFlag;
      logic       skipReq;
      logic       busy;
      logic       done;
   } estx_out_s;
endpackage : estx_pkg

// ===== tb/estx_pmem_model.sv
// estx_pmem_model: program memory that answers the table fetches of the exec unit
// assumes: word valid the cycle after pmRead, same clock as the exec unit
module estx_pmem_model #(
   parameter int unsigned AW = 16,
   parameter int unsigned DW = 16
) (
   input  wire logic          sys_clk,
   input  wire logic          pmRead,
   input  wire logic [AW-1:0] pmAddr,
   output logic      [DW-1:0] pmData
);
   timeunit 1ns;
   timeprecision 1ns;

   initial pmData = DW'(16'h5A5A);

   // ----------------------------------------------------------------
   // fetch answer
   // ----------------------------------------------------------------
   // word holds one cycle only; toggling afterwards exposes a late sample
   always @(posedge sys_clk) begin
      if (pmRead) begin
         pmData <= DW'(pmAddr ^ 16'hC35A);
      end else begin
         pmData <= ~pmData;
      end
   end
endmodule : estx_pmem_model

// ===== tb/estx_exec_tb_top.sv
// estx_exec_tb_top: self-checking bench for the skip / table-read / xor unit
// assumes: design and program memory model compiled before, 20 MHz clock
module estx_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic                  sys_clk = 1'b0;
   logic                  reset   = 1'b1;
   estx_pkg::estx_req_s   req     = '0;
   logic [15:0]           pmData;
   logic [15:0]           pmAddr;
   logic                  pmRead;
   logic [7:0]            tablePointerLow;
   logic [7:0]            tablePointerHigh;
   logic [7:0]            tableHighByteReg;
   estx_pkg::estx_out_s   result;
   logic [7:0]            accExp  = 8'h00;
   logic [7:0]            ptrExp  = 8'h00;
   logic [7:0]            lfsrVal = 8'h0E;
   int                    errors  = 0;
   int                    checked = 0;
   int                    cycles  = 0;

   // op(4) bitSel(3) byte(8): zero bytes, all ones, single-bit edges, idle op ignored
   localparam logic [14:0] CORNER [18] = '{15'h0800, 15'h0801, 15'h1000, 15'h10FF, 15'h1F7F, 15'h1801,
      15'h1BF7, 15'h1800, 15'h40FF, 15'h4800, 15'h405A, 15'h485A, 15'h2000, 15'h2800, 15'h3000, 15'h3800,
      15'h1FFF, 15'h0000};

   estx_exec estx_exec_inst (.sys_clk(sys_clk), .reset(reset), .req(req), .pmData(pmData), .pmAddr(pmAddr),
      .pmRead(pmRead), .tablePointerLow(tablePointerLow), .tablePointerHigh(tablePointerHigh),
      .tableHighByteReg(tableHighByteReg), .result(result));

   estx_pmem_model estx_pmem_model_inst (.sys_clk(sys_clk), .pmRead(pmRead), .pmAddr(pmAddr),
      .pmData(pmData));

   always #25 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsrNext(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsrNext

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one instruction: present, let it be taken, check each answer cycle
   task automatic runOp(input logic [3:0] o, input logic [2:0] bs, input logic [7:0] d);
      logic        skip;
      logic        tbl;
      logic [15:0] addr;
      logic [15:0] w;
      logic [7:0]  x;
      int          n;
      tbl  = (o[3:2] == 2'b01);
      skip = (o == 4'h3) ? !d[bs] : ((o == 4'h1 || o == 4'h2) && d == 8'h00);
      x    = accExp ^ d;
      @(posedge sys_clk);
      req <= '{1'b1, estx_pkg::estx_op_e'(o), bs, d};
      @(posedge sys_clk);
      req.valid <= 1'b0;
      #1;
      if (tbl) begin
         if (o[1]) ptrExp = ptrExp + 8'h01;
         addr = {(o[0] ? 8'hFF : 8'h00), ptrExp};
         w    = addr ^ 16'hC35A;
         chk("pmRead", 16'h1, pmRead);
         chk("busy", 16'h1, result.busy);
         chk("pmAddr", addr, pmAddr);
         chk("tablePointerLow", ptrExp, tablePointerLow);
         repeat (2) @(posedge sys_clk);
         #1;
         chk("memWe", 16'h1, result.memWe);
         chk("memWdata", w[7:0], result.memWdata);
         chk("tableHighByteReg", w[15:8], tableHighByteReg);
         chk("zeroWe", 16'h0, result.zeroWe);
         chk("done", 16'h1, result.done);
      end else begin
         chk("skipReq", skip, result.skipReq);
         chk("memWe", (o == 4'h1 || o == 4'h9), result.memWe);
         if (o == 4'h1) chk("memWdata", d, result.memWdata);
         if (o == 4'h9) chk("memWdata", x, result.memWdata);
         chk("accWe", (o == 4'h2 || o == 4'h8), result.accWe);
         chk("zeroWe", o[3], result.zeroWe);
         if (o[3]) chk("zeroFlag", (x == 8'h00), result.zeroFlag);
         if (o == 4'h8) accExp = x;
         if (o == 4'h2) accExp = d;
         chk("acc", accExp, result.acc);
         chk("done", (o != 4'h0), result.done);
         if (skip) begin
            chk("busy", 16'h1, result.busy);
            @(posedge sys_clk);
            #1;
            chk("busy", 16'h1, result.busy);
            @(posedge sys_clk);
            #1;
            chk("busy", 16'h0, result.busy);
         end
      end
      n = 0;
      while (result.busy !== 1'b0 && n < 8) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("idle", 16'h0, result.busy);
   endtask : runOp

   // ----------------------------------------------------------------
   // hang guard and main sequence
   // ----------------------------------------------------------------
   // ceiling well above the at most about 1900 cycles the sequence needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("accReset", 16'h0, result.acc);
      chk("ptrReset", 16'h0, {tablePointerHigh, tablePointerLow});
      foreach (CORNER[i]) runOp(CORNER[i][14:11], CORNER[i][10:8], CORNER[i][7:0]);
      // full lap of the low pointer to cross its wrap
      for (int i = 0; i < 256; i++) runOp(4'h6, 3'h0, 8'h00);
      for (int i = 0; i < 200; i++) begin
         lfsrVal = lfsrNext(lfsrVal);
         lfsrVal = lfsrNext(lfsrVal);
         runOp(4'(lfsrVal % 8'h09) + 4'h1, lfsrVal[7:5], lfsrNext(lfsrVal));
         lfsrVal = lfsrNext(lfsrVal);
      end
      report_and_stop();
   end
endmodule : estx_exec_tb_top
